// ===== logic/rfet_consts.vh
// register map, field positions and reset values of the rf event timer pair
`ifndef RFET_CONSTS_VH
`define RFET_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RFET_IDX_PRESET0 8'h0b
`define RFET_IDX_PRESET1 8'h0c
`define RFET_IDX_CFG0 8'h0e
`define RFET_IDX_CFG1 8'h0f
`define RFET_IDX_STATE0 8'h20
`define RFET_IDX_STATE1 8'h21

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define RFET_CFG_W 21
`define RFET_BIT_ON 0
`define RFET_BIT_RELOAD 1
`define RFET_BIT_SRC 2
`define RFET_SEL_LO 3
`define RFET_SEL_HI 5
`define RFET_BIT_NOW 6
`define RFET_LAUNCH_OWN_OFF 7
`define RFET_LAUNCH_OWN_ON 8
`define RFET_LAUNCH_EXT_GONE 9
`define RFET_LAUNCH_EXT_PRESENT 10
`define RFET_LAUNCH_TX_END 11
`define RFET_LAUNCH_TX_BEGIN 12
`define RFET_LAUNCH_RX_END 13
`define RFET_LAUNCH_RX_BEGIN 14
`define RFET_HALT_OWN_OFF 15
`define RFET_HALT_OWN_ON 16
`define RFET_HALT_EXT_GONE 17
`define RFET_HALT_EXT_PRESENT 18
`define RFET_HALT_TX_BEGIN 19
`define RFET_HALT_RX_BEGIN 20

// ----------------------------------------------------------------
// state register fields and reset values
// ----------------------------------------------------------------
`define RFET_BIT_RUNNING 20
`define RFET_CFG_RESET 21'h00000
`define RFET_PRESET_RESET 20'h00000
`define RFET_PRESC_W 8

`endif

// ===== logic/rfet_timer.v
// two event-driven down-counting timers with apb configuration registers
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "rfet_consts.vh"

// Function
// [R01] clock-source bit 0: count on every contactless interface clock tick
// [R02] clock-source bit 1: count on the prescaler output chosen by divider select
// [R03] divider select bits 5:3 halve the rate per step, 6.78 MHz down to 53 kHz
// [R04] without auto reload an expired timer stops and holds zero
// [R05] with auto reload an expired timer reloads its preset and keeps counting
// [R06] bit 0 enables the timer; only an enabled timer obeys launch and halt
// [R07] bit 20 halts the timer once a reception's first four bits arrived
// [R08] bit 19 halts the timer when a transmission begins
// [R09] bits 18 and 17 halt on external field appearing or vanishing
// [R10] bits 16 and 15 halt on own field switched on or off
// [R11] bit 14 launches the timer when the first received bit arrives
// [R12] bit 13 launches the timer when a reception ends
// [R13] bits 12 and 11 launch on transmission begin or end
// [R14] bits 10 and 9 launch on external field appearing or vanishing
// [R15] bits 8 and 7 launch on own field switched on or off
// [R16] bit 6 launches the timer at once
// [R17] each timer holds a 20-bit software-written preset value
// [R18] two independent timers with identical field layout
// [R19] launch loads the preset before counting; halt freezes the count
module rfet_timer #(
   parameter CNT_W = 20,
   parameter ADDR_W = 12
) (
   // clock, reset, clock enable
   input wire pclk,
   input wire presetn,
   input wire pce,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // contactless interface clock tick, one pclk pulse per 13.56 MHz period
   input wire contactless_interface_clock,
   // rf and transfer events, one-cycle pulses
   input wire receive_begin,
   input wire receive_nibble_done,
   input wire receive_end,
   input wire transmit_begin,
   input wire transmit_end,
   input wire external_field_present,
   input wire external_field_gone,
   input wire own_field_on,
   input wire own_field_off,
   // timer state
   output reg [1:0] timer_running,
   output reg [1:0] timer_expired
);

   // ----------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------

   // prescaler strobe: low sel+1 bits of the tick count all ones
   function presc_hit;
      input [`RFET_PRESC_W-1:0] cnt;
      input [2:0] sel;
      integer i;
      begin
         presc_hit = 1'b1;
         for (i = 0; i < `RFET_PRESC_W; i = i + 1) begin
            if ((i <= sel) && !cnt[i]) begin
               presc_hit = 1'b0;
            end
         end
      end
   endfunction

   // index of the addressed register word
   function [7:0] word_index;
      input [ADDR_W-1:0] addr;
      begin
         word_index = addr[9:2];
      end
   endfunction

   // register index of a timer's configuration word
   function [7:0] cfg_index;
      input integer tn;
      begin
         cfg_index = (tn == 0) ? `RFET_IDX_CFG0 : `RFET_IDX_CFG1;
      end
   endfunction

   // register index of a timer's preset word
   function [7:0] preset_index;
      input integer tn;
      begin
         preset_index = (tn == 0) ? `RFET_IDX_PRESET0 : `RFET_IDX_PRESET1;
      end
   endfunction

   // ----------------------------------------------------------------
   // run states of each timer
   // ----------------------------------------------------------------
   // one-hot, so a stray code falls back to idle through the default arm
   localparam [1:0] ST_IDLE = 2'h1;
   localparam [1:0] ST_COUNT = 2'h2;

   // ----------------------------------------------------------------
   // apb access decode
   // ----------------------------------------------------------------
   wire setup_phase;
   wire access_done;
   wire wr_done;
   wire [7:0] idx;
   reg [31:0] next_prdata;
   reg next_pslverr;

   assign setup_phase = psel & ~penable & ~pready;
   assign access_done = psel & penable & pready;
   // a write lands at the access edge, and only when no error was flagged
   assign wr_done = access_done & pwrite & ~pslverr;
   assign idx = word_index(paddr);

   // misaligned byte addresses count as unmapped
   wire addr_aligned;
   assign addr_aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});

   // ----------------------------------------------------------------
   // shared prescaler
   // ----------------------------------------------------------------
   // one counter serves both timers, so two timers on the same divider
   // tick together; the phase is not reset by a launch, so the first
   // prescaled step lands anywhere within one divided period
   // ticks that arrive while pce is low are lost, not queued
   reg [`RFET_PRESC_W-1:0] presc_cnt;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_cnt <= {`RFET_PRESC_W{1'b0}};
      end else if (pce && contactless_interface_clock) begin
         presc_cnt <= presc_cnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // per-timer logic
   // ----------------------------------------------------------------
   genvar t;
   generate
      for (t = 0; t < 2; t = t + 1) begin : tmr // [R18]
         // each copy owns its registers, decode and counter; only prescaler and bus are shared
         reg [`RFET_CFG_W-1:0] cfg;
         reg [CNT_W-1:0] preset;
         reg [CNT_W-1:0] cnt;
         reg [1:0] state;
         wire running;
         wire stop_now;
         wire expire_now;
         wire cfg_wr;
         wire preset_wr;
         wire step;
         wire launch;
         wire halt;
         wire now_launch;
         reg [`RFET_CFG_W-1:0] next_cfg;
         reg [CNT_W-1:0] next_preset;

         // ----------------------------------------------------------------
         // register write strobes and byte-lane merge
         // ----------------------------------------------------------------
         assign cfg_wr = wr_done && (idx == cfg_index(t));
         assign preset_wr = wr_done && (idx == preset_index(t));

         // byte-lane merge of the register writes
         always @* begin
            next_cfg = cfg;
            next_preset = preset;
            if (pstrb[0]) begin
               next_cfg[7:0] = pwdata[7:0];
               next_preset[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
               next_cfg[15:8] = pwdata[15:8];
               next_preset[15:8] = pwdata[15:8];
            end
            if (pstrb[2]) begin
               next_cfg[20:16] = pwdata[20:16];
               next_preset[CNT_W-1:16] = pwdata[CNT_W-1:16];
            end
         end

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cfg <= `RFET_CFG_RESET;
               preset <= `RFET_PRESET_RESET;
            end else if (pce) begin
               if (cfg_wr) begin
                  cfg <= next_cfg;
               end
               if (preset_wr) begin
                  preset <= next_preset; // [R17]
               end
            end
         end

         // ----------------------------------------------------------------
         // counting strobe
         // ----------------------------------------------------------------
         // counting strobe: direct tick or prescaled tick
         assign step = contactless_interface_clock & // [R01]
            (~cfg[`RFET_BIT_SRC] |
             presc_hit(presc_cnt, cfg[`RFET_SEL_HI:`RFET_SEL_LO])); // [R02] [R03]

         // ----------------------------------------------------------------
         // launch and halt decode
         // ----------------------------------------------------------------
         // immediate launch acts on the value being written
         assign now_launch = cfg_wr && next_cfg[`RFET_BIT_NOW] && next_cfg[`RFET_BIT_ON]; // [R16]

         assign launch = now_launch | (cfg[`RFET_BIT_ON] & ( // [R06]
            (cfg[`RFET_LAUNCH_RX_BEGIN] & receive_begin) | // [R11]
            (cfg[`RFET_LAUNCH_RX_END] & receive_end) | // [R12]
            (cfg[`RFET_LAUNCH_TX_BEGIN] & transmit_begin) | // [R13]
            (cfg[`RFET_LAUNCH_TX_END] & transmit_end) | // [R13]
            (cfg[`RFET_LAUNCH_EXT_PRESENT] & external_field_present) | // [R14]
            (cfg[`RFET_LAUNCH_EXT_GONE] & external_field_gone) | // [R14]
            (cfg[`RFET_LAUNCH_OWN_ON] & own_field_on) | // [R15]
            (cfg[`RFET_LAUNCH_OWN_OFF] & own_field_off))); // [R15]

         assign halt = cfg[`RFET_BIT_ON] & ( // [R06]
            (cfg[`RFET_HALT_RX_BEGIN] & receive_nibble_done) | // [R07]
            (cfg[`RFET_HALT_TX_BEGIN] & transmit_begin) | // [R08]
            (cfg[`RFET_HALT_EXT_PRESENT] & external_field_present) | // [R09]
            (cfg[`RFET_HALT_EXT_GONE] & external_field_gone) | // [R09]
            (cfg[`RFET_HALT_OWN_ON] & own_field_on) | // [R10]
            (cfg[`RFET_HALT_OWN_OFF] & own_field_off)); // [R10]

         // a write that clears the on bit stops the timer like a halt event
         assign stop_now = halt | (cfg_wr & ~next_cfg[`RFET_BIT_ON]);
         // the step that finds one or zero left expires, so a preset of n gives n steps and a preset of zero gives one
         assign expire_now = ~launch & ~stop_now & running & step & (cnt <= {{(CNT_W-1){1'b0}}, 1'b1});
         assign running = (state == ST_COUNT);

         // ----------------------------------------------------------------
         // counter and run state
         // ----------------------------------------------------------------
         // launch wins over a halt in the same cycle
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cnt <= {CNT_W{1'b0}};
               state <= ST_IDLE;
            end else if (pce) begin
               case (state)
                  ST_IDLE: begin
                     if (launch) begin
                        cnt <= preset; // [R19]
                        state <= ST_COUNT;
                     end
                  end
                  ST_COUNT: begin
                     if (launch) begin
                        cnt <= preset; // [R19]
                     end else if (stop_now) begin
                        state <= ST_IDLE; // [R19]
                     end else if (expire_now) begin
                        if (cfg[`RFET_BIT_RELOAD]) begin
                           cnt <= preset; // [R05]
                        end else begin
                           cnt <= {CNT_W{1'b0}}; // [R04]
                           state <= ST_IDLE; // [R04]
                        end
                     end else if (step) begin
                        cnt <= cnt - 1'b1;
                     end
                  end
                  default: begin
                     state <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // timer state outputs
   // ----------------------------------------------------------------
   // one process drives both bits; flags trail the internal state by one cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_running <= 2'h0;
         timer_expired <= 2'h0;
      end else if (pce) begin
         timer_running <= {tmr[1].running, tmr[0].running};
         timer_expired <= {tmr[1].expire_now, tmr[0].expire_now};
      end
   end

   // ----------------------------------------------------------------
   // read mux and unmapped detection
   // ----------------------------------------------------------------
   // state words are read only; a write to them is dropped without an error
   always @* begin
      next_prdata = 32'h00000000;
      next_pslverr = 1'b0;
      if (!addr_aligned) begin
         next_pslverr = 1'b1;
      end else if (idx == `RFET_IDX_PRESET0) begin
         next_prdata[CNT_W-1:0] = tmr[0].preset;
      end else if (idx == `RFET_IDX_PRESET1) begin
         next_prdata[CNT_W-1:0] = tmr[1].preset;
      end else if (idx == `RFET_IDX_CFG0) begin
         next_prdata[`RFET_CFG_W-1:0] = tmr[0].cfg;
      end else if (idx == `RFET_IDX_CFG1) begin
         next_prdata[`RFET_CFG_W-1:0] = tmr[1].cfg;
      end else if (idx == `RFET_IDX_STATE0) begin
         next_prdata[CNT_W-1:0] = tmr[0].cnt;
         next_prdata[`RFET_BIT_RUNNING] = tmr[0].running;
      end else if (idx == `RFET_IDX_STATE1) begin
         next_prdata[CNT_W-1:0] = tmr[1].cnt;
         next_prdata[`RFET_BIT_RUNNING] = tmr[1].running;
      end else begin
         next_pslverr = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // apb answer: ready in the first access cycle, no wait states
   // ----------------------------------------------------------------
   // read data is captured at the end of setup; a state register read
   // shows the count as it stood then, one cycle before the access edge
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (pce) begin
         if (setup_phase) begin
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
         end else if (access_done) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
         end
      end
   end

endmodule

// ===== dv/rfet_timer_chk.sv
// assertion checker for the rf event timer pair, bound to its top module
`timescale 1ns/1ps
module rfet_timer_chk #(parameter CNT_W = 20, parameter ADDR_W = 12) (
   // clock, reset and apb
   input wire pclk, presetn, pce, psel, penable, pwrite, pready, pslverr,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata, prdata,
   input wire [3:0] pstrb,
   // tick and events
   input wire contactless_interface_clock, receive_begin, receive_nibble_done, receive_end,
   input wire transmit_begin, transmit_end, external_field_present, external_field_gone,
   input wire own_field_on, own_field_off,
   // timer state
   input wire [1:0] timer_running, timer_expired
);
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   wire setup = psel && !penable && pce;
   // anything that may legally move a timer; a change with no cause is a fault
   wire cause = contactless_interface_clock | receive_begin | receive_nibble_done | receive_end | transmit_begin |
      transmit_end | external_field_present | external_field_gone | own_field_on | own_field_off | (psel & penable);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   apb_answer_a:
   assert property (setup |=> pready) else $error("no pready after setup");
   ready_pulse_a:
   assert property (pready && pce |=> !pready) else $error("pready held too long");
   err_ready_a:
   assert property (pslverr |-> pready) else $error("pslverr without pready");
   idle_data_a:
   assert property (!pready |-> prdata == 32'h00000000) else $error("prdata not zero when idle");
   align_err_a:
   assert property (setup && paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned access not refused");
   range_err_a:
   assert property (setup && |paddr[ADDR_W-1:10] |=> pslverr) else $error("out of range access not refused");
   expiry_tick_a:
   assert property (timer_expired != 2'h0 |-> $past(contactless_interface_clock) ||
      $past(contactless_interface_clock, 2)) else $error("expiry without a tick");
   expiry_running_a:
   assert property ((timer_expired & ~timer_running) == 2'h0) else $error("expiry of an idle timer");
   run_cause_a:
   assert property ($changed(timer_running) |-> $past(cause, 2) || $past(cause, 3)) else $error("running moved alone");
endmodule

bind rfet_timer rfet_timer_chk #(.CNT_W(CNT_W), .ADDR_W(ADDR_W)) chk_u (.pclk, .presetn, .pce, .psel, .penable,
   .pwrite, .pready, .pslverr, .paddr, .pwdata, .prdata, .pstrb, .contactless_interface_clock, .receive_begin,
   .receive_nibble_done, .receive_end, .transmit_begin, .transmit_end, .external_field_present,
   .external_field_gone, .own_field_on, .own_field_off, .timer_running, .timer_expired);

// ===== dv/rfet_timer_tb_top.sv
// self-checking testbench for the rf event timer pair
`timescale 1ns/1ps
`include "rfet_consts.vh"
module rfet_timer_tb_top;
   localparam logic [11:0] P0 = {2'h0, `RFET_IDX_PRESET0, 2'h0}, P1 = {2'h0, `RFET_IDX_PRESET1, 2'h0};
   localparam logic [11:0] C0 = {2'h0, `RFET_IDX_CFG0, 2'h0}, C1 = {2'h0, `RFET_IDX_CFG1, 2'h0};
   localparam logic [11:0] S0 = {2'h0, `RFET_IDX_STATE0, 2'h0}, S1 = {2'h0, `RFET_IDX_STATE1, 2'h0};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0, re;
   logic pce = 1'b1, hung = 1'b0;
   logic [3:0] pstrb = 4'hf;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, rv;
   logic [8:0] ev = 9'h000;
   wire [31:0] prdata;
   wire pready, pslverr;
   wire [1:0] timer_running, timer_expired;
   integer err_count = 0, checked = 0, ex0 = 0, ex1 = 0;
   always #4 pclk = ~pclk;
   always @(posedge pclk) if (timer_expired[0] === 1'b1) ex0 <= ex0 + 1;
   always @(posedge pclk) if (timer_expired[1] === 1'b1) ex1 <= ex1 + 1;
   rfet_timer dut_u (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .contactless_interface_clock(tick), .receive_begin(ev[0]), .receive_end(ev[1]),
      .transmit_begin(ev[2]), .transmit_end(ev[3]), .external_field_present(ev[4]), .external_field_gone(ev[5]),
      .own_field_on(ev[6]), .own_field_off(ev[7]), .receive_nibble_done(ev[8]), .timer_running, .timer_expired);
   // ----------------------------------------------------------------
   // bus, tick and event tasks
   // ----------------------------------------------------------------
   task results;
      if (err_count == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      integer n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
      rv = prdata;
      re = pslverr;
      if (pready !== 1'b1) begin
         chk("pready", 32'h0, 32'h1);
         // the watchdog branch of the main sequence then closes the run
         hung = 1'b1;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, rv, exp);
   endtask
   // ticks two cycles apart so every tick is a step of its own
   task tk(input integer n);
      repeat (n) begin
         tick <= 1'b1;
         @(posedge pclk);
         tick <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task pulse(input integer i);
      ev[i] <= 1'b1;
      @(posedge pclk);
      ev <= 9'h000;
      repeat (2) @(posedge pclk);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_regs;
      rd(C0, 32'h0, "cfg0 reset");
      rd(P0, 32'h0, "preset0 reset");
      apb(1'b1, C1, 32'hfffffffe);
      rd(C1, 32'h001ffffe, "cfg1 fields");
      apb(1'b1, P1, 32'hffffffff);
      rd(P1, 32'h000fffff, "preset1 width");
      pstrb <= 4'h5;
      apb(1'b1, P1, 32'h0);
      pstrb <= 4'hf;
      rd(P1, 32'h0000ff00, "preset1 byte lanes");
      apb(1'b1, S0, 32'h000fffff);
      rd(S0, 32'h0, "state read only");
      apb(1'b1, C1, 32'h0);
      apb(1'b0, 12'h014, 32'h0);
      chk("unmapped error", {31'h0, re}, 32'h1);
      apb(1'b0, 12'h039, 32'h0);
      chk("misaligned error", {31'h0, re}, 32'h1);
      apb(1'b1, 12'h039, 32'h00000041);
      chk("refused write error", {31'h0, re}, 32'h1);
      rd(C0, 32'h0, "refused write ignored");
   endtask
   task t_launch;
      integer i;
      apb(1'b1, P0, 32'h00000400);
      for (i = 0; i < 8; i++) begin
         apb(1'b1, C0, 32'h1 << (14 - i));
         pulse(i);
         chk("launch while off", {30'h0, timer_running}, 32'h0);
         apb(1'b1, C0, (32'h1 << (14 - i)) | 32'h1);
         pulse(i);
         chk("launch on event", {30'h0, timer_running}, 32'h1);
         apb(1'b1, C0, 32'h0);
      end
      apb(1'b1, C0, 32'h41);
      rd(S0, 32'h00100400, "launch now");
      apb(1'b1, C0, 32'h0);
   endtask
   task t_halt;
      integer k;
      integer hv[6];
      hv = '{8, 2, 4, 5, 6, 7};
      apb(1'b1, P0, 32'h00000064);
      for (k = 0; k < 6; k++) begin
         apb(1'b1, C0, (32'h1 << (20 - k)) | 32'h41);
         tk(3);
         pulse(hv[k]);
         tk(2);
         rd(S0, 32'h00000061, "halt freezes");
         apb(1'b1, C0, 32'h0);
      end
   endtask
   task t_expire;
      integer b;
      apb(1'b1, P1, 32'h5);
      b = ex1;
      apb(1'b1, C1, 32'h41);
      tk(4);
      rd(S1, 32'h00100001, "direct steps");
      tk(4);
      rd(S1, 32'h0, "expired holds zero");
      chk("single expiry", ex1 - b, 32'h1);
      apb(1'b1, P1, 32'h3);
      b = ex1;
      apb(1'b1, C1, 32'h43);
      tk(7);
      rd(S1, 32'h00100002, "reload count");
      chk("reload expiries", ex1 - b, 32'h2);
      apb(1'b1, C1, 32'h0);
   endtask
   // free-running prescaler phase: only a window of tick counts can be exact
   task t_presc;
      integer s, n, d, b;
      apb(1'b1, P1, 32'h2);
      for (s = 0; s < 8; s++) begin
         b = ex1;
         apb(1'b1, C1, (s << 3) | 32'h45);
         for (n = 0; n < 600 && ex1 == b; n++) tk(1);
         d = 2 << s;
         chk("prescaled ticks", {31'h0, n > d && n <= 2 * d + 1}, 32'h1);
         apb(1'b1, C1, 32'h0);
      end
   endtask
   // pce low freezes the counter of a directly ticked timer; timer one must ignore timer zero
   task t_freeze;
      integer b0, b1;
      apb(1'b1, P0, 32'h3);
      apb(1'b1, C1, 32'h00002001);
      b0 = ex0;
      b1 = ex1;
      apb(1'b1, C0, 32'h41);
      tk(1);
      pce <= 1'b0;
      tk(4);
      pce <= 1'b1;
      rd(S0, 32'h00100002, "frozen count");
      tk(2);
      rd(S0, 32'h0, "timer zero expired");
      chk("timer zero expiries", ex0 - b0, 32'h1);
      chk("timer one untouched", {30'h0, timer_running}, 32'h0);
      chk("timer one expiries", ex1 - b1, 32'h0);
      apb(1'b1, C0, 32'h0);
      apb(1'b1, C1, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      fork
         begin
            t_regs;
            t_launch;
            t_halt;
            t_expire;
            t_presc;
            t_freeze;
         end
         wait (hung);
      join_any
      results;
   end
endmodule
